/* design/can_mcs_pkg.sv */
// constants, types and decode helpers for the CAN mode/control/status block
// assumes a 32-bit AXI4-Lite register port and one core clock
// What this block does
// - mode_request 1xx asks configuration, 011 listen, 010 loopback, 001 disable, 000 normal
// - mode_status reports mode in effect; 101..111 never shown
// - abort_all_tx set by software cancels pending transmissions in all buffers
// - legacy window field picks buffer: 101 rx1, 100 tx0, 011 tx1, 010 tx2, else rx0
// - in FIFO format control low nibble is read-only fifo_read_pointer
// - status shows prioritised source code; legacy uses status bits 3..1
// - codes: none 0, error 02, tx2 04, tx1 06, tx0 08, legacy rx1 0A, rx0 0C
// - wake 0E in every format; enhanced: rx 10/11 (both 10 in FIFO format), programmable 12..17, programmable receiver gives 10
// - codes line up so copying them into window select maps the source buffer
// - configuration request waits for idle bus; other requests apply at once
package can_mcs_pkg;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STAT     = 8'h04;
  localparam logic [7:0] OFS_ECTRL    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [2:0] RST_MODE_REQ = 3'h4;
  localparam int CTRL_REQ_LSB   = 5;
  localparam int CTRL_ABORT_BIT = 4;
  localparam int CTRL_WIN_LSB   = 1;
  localparam int ECTRL_FMT_LSB  = 6;
  localparam int IRQ_W          = 13;
  localparam int IRQ_WAKE       = 6;
  localparam int IRQ_PROG0      = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0, MODE_DISABLE = 3'h1, MODE_LOOPBACK = 3'h2,
    MODE_LISTEN = 3'h3, MODE_CONFIG = 3'h4
  } op_mode_t;
  typedef enum logic [1:0] {
    FMT_LEGACY = 2'h0, FMT_ENH_LEGACY = 2'h1, FMT_FIFO = 2'h2
  } buf_fmt_t;
  typedef enum logic [2:0] {
    BUF_RX0 = 3'h0, BUF_RX1 = 3'h1, BUF_TX0 = 3'h2, BUF_TX1 = 3'h3,
    BUF_TX2 = 3'h4
  } buf_id_t;
  // source order: err, tx2, tx1, tx0, rx1, rx0, wake, prog0..5
  localparam logic [4:0] IC_NONE = 5'h00;
  localparam logic [4:0] IC_ERR  = 5'h02;
  localparam logic [4:0] IC_TX2  = 5'h04;
  localparam logic [4:0] IC_TX1  = 5'h06;
  localparam logic [4:0] IC_TX0  = 5'h08;
  localparam logic [4:0] IC_LRX1 = 5'h0A;
  localparam logic [4:0] IC_LRX0 = 5'h0C;
  localparam logic [4:0] IC_WAKE = 5'h0E;
  localparam logic [4:0] IC_RX0  = 5'h10;
  localparam logic [4:0] IC_RX1  = 5'h11;
  localparam logic [4:0] IC_PROG = 5'h12;

  function automatic buf_id_t win_to_buf(input logic [2:0] win);
    unique case (win)
      3'h5:    win_to_buf = BUF_RX1;
      3'h4:    win_to_buf = BUF_TX0;
      3'h3:    win_to_buf = BUF_TX1;
      3'h2:    win_to_buf = BUF_TX2;
      default: win_to_buf = BUF_RX0;
    endcase
  endfunction
endpackage

/* design/mode_link_if.sv */
// carries the mode request into the sequencer and the live mode back out
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface mode_link_if;
  import can_mcs_pkg::*;
  logic [2:0] mode_req;
  logic       bus_idle;
  op_mode_t   mode_now;
  modport seq (input mode_req, input bus_idle, output mode_now);
  modport ctl (output mode_req, output bus_idle, input mode_now);
endinterface
`default_nettype wire

/* design/mode_sequencer.sv */
// applies mode requests; configuration entry waits for an idle bus
// assumes bus_idle comes from protocol logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module mode_sequencer
  import can_mcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  mode_link_if.seq link
);
  typedef enum logic {SEQ_APPLIED = 1'b0, SEQ_WAIT_IDLE = 1'b1} seq_state_t;
  seq_state_t state_ff;
  op_mode_t   mode_ff;
  op_mode_t   req_plain;

  assign req_plain     = op_mode_t'({1'b0, link.mode_req[1:0]});
  assign link.mode_now = mode_ff;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff  <= MODE_CONFIG;
      state_ff <= SEQ_APPLIED;
    end else if (clk_en) begin
      unique case (state_ff)
        SEQ_APPLIED: begin
          if (link.mode_req[2] && mode_ff != MODE_CONFIG) begin
            if (link.bus_idle) begin
              mode_ff <= MODE_CONFIG;
            end else begin
              state_ff <= SEQ_WAIT_IDLE;
            end
          end else if (!link.mode_req[2]) begin
            mode_ff <= req_plain;
          end
        end
        SEQ_WAIT_IDLE: begin
          if (!link.mode_req[2]) begin
            mode_ff  <= req_plain;
            state_ff <= SEQ_APPLIED;
          end else if (link.bus_idle) begin
            mode_ff  <= MODE_CONFIG;
            state_ff <= SEQ_APPLIED;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* design/irq_code_encoder.sv */
// priority encoder from pending sources to the interrupt source code
// assumes pending is already masked; lower index wins
`timescale 1ns/1ps
`default_nettype none
module irq_code_encoder
  import can_mcs_pkg::*;
(
  input  wire logic [IRQ_W-1:0] pending,
  input  wire logic [1:0]       fmt,
  input  wire logic [5:0]       prog_is_rx,
  output logic      [4:0]       code
);
  function automatic logic [4:0] src_code(input int idx,
                                          input logic [1:0] f,
                                          input logic [5:0] is_rx);
    logic leg;
    leg = (f == FMT_LEGACY);
    case (idx)
      0: src_code = IC_ERR;
      1: src_code = IC_TX2;
      2: src_code = IC_TX1;
      3: src_code = IC_TX0;
      4: src_code = leg ? IC_LRX1 :
                    (f == FMT_FIFO ? IC_RX0 : IC_RX1);
      5: src_code = leg ? IC_LRX0 : IC_RX0;
      6: src_code = IC_WAKE;
      default: src_code = is_rx[idx-IRQ_PROG0] ? IC_RX0 :
                          IC_PROG + 5'(idx - IRQ_PROG0);
    endcase
  endfunction

  always_comb begin
    code = IC_NONE;
    for (int i = IRQ_W - 1; i >= 0; i--) begin
      if (pending[i]) begin
        code = src_code(i, fmt, prog_is_rx);
      end
    end
  end
endmodule
`default_nettype wire

/* design/can_mode_control_status.sv */
// top of the CAN mode/control/status front end with its AXI4-Lite slave
// assumes engine inputs (events, bus_idle, pointers) share sys_clk
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module can_mode_control_status
  import can_mcs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        bus_idle,
  input  wire logic [2:0]  tx_pending,
  input  wire logic        evt_err,
  input  wire logic [2:0]  evt_tx,
  input  wire logic [1:0]  evt_rx,
  input  wire logic        evt_wake,
  input  wire logic [5:0]  evt_prog,
  input  wire logic [5:0]  prog_is_rx,
  input  wire logic [3:0]  fifo_read_pointer,
  output logic [2:0]       mode_status,
  output logic             abort_all_tx,
  output logic [2:0]       buffer_window_select,
  output logic [2:0]       window_buffer,
  output logic [4:0]       enhanced_window_select,
  output logic [1:0]       buffer_format,
  output logic             irq
);
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, OFS_CTRL) | hit(a, OFS_STAT) | hit(a, OFS_ECTRL) |
             hit(a, OFS_IRQ_STAT) | hit(a, OFS_IRQ_MASK);
  endfunction

  function automatic logic [IRQ_W-1:0] lanes(input logic [3:0] s);
    lanes = {{(IRQ_W-8){s[1]}}, {8{s[0]}}};
  endfunction

  logic             awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]       bresp_ff, rresp_ff;
  logic [31:0]      rdata_ff, wdata_ff;
  logic [7:0]       awaddr_ff;
  logic [3:0]       wstrb_ff;
  logic             aw_held_ff, w_held_ff;
  logic [2:0]       mode_req_ff, win_ff;
  buf_id_t          window_buffer_ff;
  logic             abort_ff;
  buf_fmt_t         fmt_ff;
  logic [4:0]       enh_win_ff;
  logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  logic             irq_ff;
  logic             aw_hs, w_hs, ar_hs, wr_fire;
  logic             nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid;
  logic             wr_ctrl, wr_ectrl, wr_istat, wr_imask;
  logic [IRQ_W-1:0] evt_vec, pending;
  logic [4:0]       code;
  logic [31:0]      rd_word;
  op_mode_t         mode_now;

  mode_link_if link ();
  assign link.mode_req = mode_req_ff;
  assign link.bus_idle = bus_idle;
  assign mode_now      = link.mode_now;

  mode_sequencer u_seq (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .link    (link)
  );

  assign pending = irq_stat_ff & irq_mask_ff;

  irq_code_encoder u_enc (
    .pending    (pending),
    .fmt        (fmt_ff),
    .prog_is_rx (prog_is_rx),
    .code       (code)
  );

  // write channel: address and data taken in either order
  assign aw_hs       = awvalid & awready_ff;
  assign w_hs        = wvalid & wready_ff;
  assign wr_fire     = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign nxt_aw_held = ~wr_fire & (aw_held_ff | aw_hs);
  assign nxt_w_held  = ~wr_fire & (w_held_ff | w_hs);
  assign nxt_bvalid  = wr_fire | (bvalid_ff & ~bready);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else if (clk_en) begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      bvalid_ff  <= nxt_bvalid;
      awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_held & ~nxt_bvalid;
      if (aw_hs) begin
        awaddr_ff <= awaddr;
      end
      if (w_hs) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_fire) begin
        bresp_ff <= mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign wr_ctrl  = wr_fire & hit(awaddr_ff, OFS_CTRL) & wstrb_ff[0];
  assign wr_ectrl = wr_fire & hit(awaddr_ff, OFS_ECTRL) & wstrb_ff[0];
  assign wr_istat = wr_fire & hit(awaddr_ff, OFS_IRQ_STAT);
  assign wr_imask = wr_fire & hit(awaddr_ff, OFS_IRQ_MASK);

  // control register: mode request and legacy window
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_req_ff      <= RST_MODE_REQ;
      win_ff           <= 3'h0;
      window_buffer_ff <= BUF_RX0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        mode_req_ff <= wdata_ff[CTRL_REQ_LSB +: 3];
      end
      if (fmt_ff != FMT_LEGACY) begin
        win_ff           <= 3'h0;
        window_buffer_ff <= BUF_RX0;
      end else if (wr_ctrl) begin
        win_ff           <= wdata_ff[CTRL_WIN_LSB +: 3];
        window_buffer_ff <= win_to_buf(wdata_ff[CTRL_WIN_LSB +: 3]);
      end
    end
  end

  // abort request: software sets, cleared once nothing is pending
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      abort_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl && wdata_ff[CTRL_ABORT_BIT]) begin
        abort_ff <= 1'b1;
      end else if (tx_pending == 3'h0) begin
        abort_ff <= 1'b0;
      end
    end
  end

  // buffer format and enhanced window
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_ff     <= FMT_LEGACY;
      enh_win_ff <= 5'h00;
    end else if (clk_en) begin
      if (wr_ectrl && mode_now == MODE_CONFIG &&
          wdata_ff[ECTRL_FMT_LSB +: 2] != 2'h3) begin
        fmt_ff <= buf_fmt_t'(wdata_ff[ECTRL_FMT_LSB +: 2]);
      end
      if (fmt_ff == FMT_LEGACY) begin
        enh_win_ff <= 5'h00;
      end else if (wr_ectrl) begin
        enh_win_ff <= wdata_ff[4:0];
      end
    end
  end

  // sticky event flags, write one to clear, set wins over clear
  assign evt_vec = {evt_prog & {6{fmt_ff != FMT_LEGACY}}, evt_wake,
                    evt_rx[0], evt_rx[1], evt_tx[0], evt_tx[1], evt_tx[2],
                    evt_err};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      irq_ff      <= 1'b0;
    end else if (clk_en) begin
      irq_stat_ff <= (irq_stat_ff &
                      ~(wr_istat ? wdata_ff[IRQ_W-1:0] & lanes(wstrb_ff)
                                 : '0)) | evt_vec;
      if (wr_imask) begin
        irq_mask_ff <= (irq_mask_ff & ~lanes(wstrb_ff)) |
                       (wdata_ff[IRQ_W-1:0] & lanes(wstrb_ff));
      end
      irq_ff <= |pending;
    end
  end

  // read channel: answer one cycle after the address is taken
  assign ar_hs      = arvalid & arready_ff;
  assign nxt_rvalid = ar_hs | (rvalid_ff & ~rready);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(araddr, OFS_CTRL)) begin
      rd_word[7:4] = {mode_req_ff, abort_ff};
      unique case (fmt_ff)
        FMT_LEGACY: rd_word[3:0] = {win_ff, 1'b0};
        FMT_FIFO:   rd_word[3:0] = fifo_read_pointer;
        default:    rd_word[3:0] = 4'h0;
      endcase
    end else if (hit(araddr, OFS_STAT)) begin
      rd_word[7:5] = mode_now;
      rd_word[4:0] = (fmt_ff == FMT_LEGACY) ? {1'b0, code[3:1], 1'b0}
                                            : code;
    end else if (hit(araddr, OFS_ECTRL)) begin
      rd_word[7:0] = {fmt_ff, 1'b0, enh_win_ff};
    end else if (hit(araddr, OFS_IRQ_STAT)) begin
      rd_word[IRQ_W-1:0] = irq_stat_ff;
    end else if (hit(araddr, OFS_IRQ_MASK)) begin
      rd_word[IRQ_W-1:0] = irq_mask_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else if (clk_en) begin
      rvalid_ff  <= nxt_rvalid;
      arready_ff <= ~nxt_rvalid;
      if (ar_hs) begin
        rdata_ff <= rd_word;
        rresp_ff <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign awready                = awready_ff;
  assign wready                 = wready_ff;
  assign bvalid                 = bvalid_ff;
  assign bresp                  = bresp_ff;
  assign arready                = arready_ff;
  assign rvalid                 = rvalid_ff;
  assign rdata                  = rdata_ff;
  assign rresp                  = rresp_ff;
  assign mode_status            = mode_now;
  assign abort_all_tx           = abort_ff;
  assign buffer_window_select   = win_ff;
  assign window_buffer          = window_buffer_ff;
  assign enhanced_window_select = enh_win_ff;
  assign buffer_format          = fmt_ff;
  assign irq                    = irq_ff;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_cfg_waits_idle: assert property (
    clk_en && mode_req_ff[2] && mode_now != MODE_CONFIG && !bus_idle
    |=> mode_now != MODE_CONFIG)
    else $error("configuration entered while bus busy");
  a_plain_mode_now: assert property (
    clk_en && !mode_req_ff[2] |=> mode_now == {1'b0, $past(mode_req_ff[1:0])})
    else $error("plain mode request not applied next cycle");
  a_status_legal: assert property (
    mode_now[2] |-> mode_now[1:0] == 2'h0)
    else $error("reserved mode status code");
  a_reset_state: assert property (
    $rose(rst_b) |-> mode_req_ff == RST_MODE_REQ && mode_now == MODE_CONFIG
    && !abort_ff && !irq_ff)
    else $error("wrong state after reset release");
  a_abort_sets: assert property (
    clk_en && wr_ctrl && wdata_ff[CTRL_ABORT_BIT] |=> abort_all_tx)
    else $error("abort not set by software write");
  a_win_ignored: assert property (
    fmt_ff != FMT_LEGACY |=> buffer_window_select == 3'h0)
    else $error("window bits alive outside legacy format");
  a_win_decode: assert property (
    clk_en && wr_ctrl && fmt_ff == FMT_LEGACY
    && wdata_ff[CTRL_WIN_LSB +: 3] == 3'h5 |=> window_buffer == BUF_RX1)
    else $error("window 101 not mapped to receive buffer 1");
  a_fifo_ptr_read: assert property (
    clk_en && ar_hs && hit(araddr, OFS_CTRL) && fmt_ff == FMT_FIFO
    |=> rvalid && rdata[3:0] == $past(fifo_read_pointer))
    else $error("fifo pointer not returned on control read");
  a_err_code: assert property (
    pending[0] |-> code == IC_ERR)
    else $error("error source code wrong");
  a_prog_rx_code: assert property (
    fmt_ff != FMT_LEGACY && pending == (IRQ_W'(1) << IRQ_PROG0)
    && prog_is_rx[0] |-> code == IC_RX0)
    else $error("programmable receiver code wrong");
  a_irq_level: assert property (
    clk_en && (|pending) ##1 clk_en && (|pending) |-> irq)
    else $error("interrupt output low with pending source");

  c_cfg_entry: cover property (mode_req_ff[2] && !bus_idle ##[1:20]
                               $rose(mode_now == MODE_CONFIG));
  c_abort_done: cover property ($rose(abort_all_tx) ##[1:50] !abort_all_tx);
  c_wake_irq: cover property (pending[IRQ_WAKE] && irq);
  c_fifo_read: cover property (rvalid && fmt_ff == FMT_FIFO);
endmodule
`default_nettype wire

/* verification/can_far_side.sv */
// far-side model: other nodes keep the bus busy, buffers wait, events pulse
// assumes bench commands change just after a rising edge of sys_clk
`timescale 1ns/1ps
`default_nettype none
module can_far_side (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [4:0]  frame_len,
  input  wire logic [2:0]  tx_load,
  input  wire logic [12:0] evt_cmd,
  input  wire logic        abort_all_tx,
  output logic             bus_idle,
  output logic [2:0]       tx_pending,
  output logic [12:0]      evt_pulse
);
  logic [4:0] busy_ff;
  assign bus_idle = (busy_ff == 5'h00);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff    <= 5'h00;
      tx_pending <= 3'h0;
      evt_pulse  <= 13'h0000;
    end else begin
      // a frame keeps the bus busy for frame_len cycles
      if (frame_len != 5'h00)
        busy_ff <= frame_len;
      else if (busy_ff != 5'h00)
        busy_ff <= busy_ff - 5'h01;
      // queued frames vanish once the abort reaches them
      tx_pending <= abort_all_tx ? 3'h0 : (tx_pending | tx_load);
      evt_pulse  <= evt_cmd;
    end
  end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the CAN mode/control/status block
// assumes an AXI4-Lite master here and the far-side model on engine ports
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import can_mcs_pkg::*;
  logic        sys_clk, rst_b;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, bus_idle, irq;
  logic [1:0]  bresp, rresp, r, buffer_format;
  logic [2:0]  tx_pending, tx_load, mode_status, buffer_window_select;
  logic [2:0]  window_buffer;
  logic        abort_all_tx, clk_en;
  logic [12:0] ev, evt_cmd;
  logic [5:0]  prog_is_rx;
  logic [3:0]  fifo_ptr;
  logic [4:0]  enhanced_window_select, frame_len, e;
  int          err_total, checks;
  logic [2:0]  wexp [8] = '{3'h0, 3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
  logic [2:0]  sbuf [7] = '{3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h0};
  logic [4:0]  lcode [7] = '{5'h02, 5'h04, 5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E};

  can_mode_control_status dut (
    .sys_clk, .rst_b, .clk_en, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .bus_idle, .tx_pending, .evt_err(ev[0]), .evt_tx({ev[1], ev[2], ev[3]}),
    .evt_rx({ev[4], ev[5]}), .evt_wake(ev[6]), .evt_prog(ev[12:7]),
    .prog_is_rx, .fifo_read_pointer(fifo_ptr), .mode_status, .abort_all_tx,
    .buffer_window_select, .window_buffer, .enhanced_window_select,
    .buffer_format, .irq
  );
  can_far_side peer (
    .sys_clk, .rst_b, .frame_len, .tx_load, .evt_cmd, .abort_all_tx,
    .bus_idle, .tx_pending, .evt_pulse(ev)
  );

  always #25 sys_clk = ~sys_clk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    // no write response in time counts as a mismatch
    if (n == 40) err_total++;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    // no read data in time counts as a mismatch
    if (n == 40) err_total++;
    #1;
  endtask

  task automatic pulse(input logic [12:0] v);
    @(posedge sys_clk);
    evt_cmd <= v;
    @(posedge sys_clk);
    evt_cmd <= 13'h0000;
    tick(3);
  endtask

  task automatic go_mode(input logic [2:0] q, input logic [2:0] x);
    wr(OFS_CTRL, {24'h0, q, 5'h00});
    for (int n = 0; n < 40; n++) begin
      rd(OFS_STAT);
      if (d[7:5] === x) break;
    end
    chk({d[7:5], mode_status}, {x, x});
  endtask

  task automatic t_reset();
    chk({mode_status, abort_all_tx, irq, window_buffer}, 32'h80);
    rd(OFS_CTRL);
    chk(d, 32'h80);
    rd(OFS_ECTRL);
    chk(d, 32'h0);
    rd(OFS_IRQ_MASK);
    chk(d, 32'h0);
    wr(OFS_STAT, 32'h7F);
    rd(OFS_STAT);
    chk(d, 32'h80);
    rd(8'h14);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(8'h14, 32'hFF);
    chk(r, RESP_SLVERR);
    $display("reset test done");
  endtask

  task automatic t_mode();
    for (int m = 0; m < 8; m++)
      go_mode(3'(m), m[2] ? 3'h4 : 3'(m));
    go_mode(3'h3, 3'h3);
    @(posedge sys_clk);
    frame_len <= 5'h18;
    @(posedge sys_clk);
    frame_len <= 5'h00;
    wr(OFS_CTRL, 32'hA0);
    chk(mode_status, 3'h3);
    go_mode(3'h5, 3'h4);
    chk(bus_idle, 1'b1);
    $display("mode test done");
  endtask

  task automatic t_abort();
    @(posedge sys_clk);
    tx_load <= 3'h5;
    @(posedge sys_clk);
    tx_load <= 3'h0;
    wr(OFS_CTRL, 32'h90);
    chk({abort_all_tx, tx_pending}, 4'h8);
    tick(2);
    chk(abort_all_tx, 1'b0);
    rd(OFS_CTRL);
    chk(d, 32'h80);
    $display("abort test done");
  endtask

  task automatic t_window();
    for (int w = 0; w < 8; w++) begin
      wr(OFS_CTRL, {24'h0, 4'h8, w[2:0], 1'b0});
      rd(OFS_CTRL);
      chk(d, {24'h0, 4'h8, w[2:0], 1'b0});
      chk({buffer_window_select, window_buffer}, {w[2:0], wexp[w]});
    end
    $display("window test done");
  endtask

  task automatic t_irq();
    wr(OFS_IRQ_MASK, 32'h1FFF);
    for (int s = 0; s < 7; s++) begin
      pulse(13'h1 << s);
      chk(irq, 1'b1);
      rd(OFS_STAT);
      chk(d, {24'h0, 3'h4, lcode[s]});
      wr(OFS_CTRL, {24'h0, 4'h8, d[3:1], 1'b0});
      chk(window_buffer, sbuf[s]);
      wr(OFS_IRQ_STAT, 32'h1 << s);
      tick(1);
      chk(irq, 1'b0);
    end
    // events arriving while the clock enable is low are not seen
    @(posedge sys_clk);
    clk_en <= 1'b0;
    pulse(13'h0001);
    chk(irq, 1'b0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(OFS_IRQ_STAT);
    chk(d, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1FFE);
    pulse(13'h0009);
    rd(OFS_STAT);
    chk(d[4:0], 5'h08);
    wr(OFS_IRQ_MASK, 32'h0);
    tick(1);
    rd(OFS_STAT);
    chk({irq, d[4:0]}, 6'h00);
    wr(OFS_IRQ_MASK, 32'h1FFF);
    rd(OFS_STAT);
    chk(d[4:0], 5'h02);
    wr(OFS_IRQ_STAT, 32'h9);
    $display("legacy irq test done");
  endtask

  task automatic t_enh();
    wr(OFS_ECTRL, 32'h40);
    wr(OFS_CTRL, 32'h8E);
    rd(OFS_CTRL);
    chk(buffer_format, 2'h1);
    chk(d, 32'h80);
    for (int s = 4; s < 13; s++) begin
      e = (s == 4) ? 5'h11 : (s == 5) ? 5'h10 : (s == 6) ? 5'h0E :
          prog_is_rx[s - 7] ? 5'h10 : 5'(s + 11);
      pulse(13'h1 << s);
      rd(OFS_STAT);
      chk(d[4:0], e);
      wr(OFS_ECTRL, {24'h0, 3'h2, d[4:0]});
      chk(enhanced_window_select, e);
      wr(OFS_IRQ_STAT, 32'h1 << s);
    end
    $display("enhanced test done");
  endtask

  task automatic t_fifo();
    wr(OFS_ECTRL, 32'h80);
    wr(OFS_CTRL, 32'h88);
    rd(OFS_CTRL);
    chk(d, 32'h87);
    @(posedge sys_clk);
    fifo_ptr <= 4'h3;
    rd(OFS_CTRL);
    chk(d, 32'h83);
    pulse(13'h0010);
    rd(OFS_STAT);
    chk(d, 32'h90);
    wr(OFS_IRQ_STAT, 32'h10);
    $display("fifo test done");
  endtask

  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, frame_len, tx_load, evt_cmd} = '0;
    prog_is_rx = 6'h05;
    fifo_ptr = 4'h7;
    clk_en = 1'b1;
    err_total = 0;
    checks = 0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    tick(3);
    t_reset();
    t_mode();
    t_abort();
    t_window();
    t_irq();
    t_enh();
    t_fifo();
    go_mode(3'h1, 3'h1);
    stop_test();
  end

  initial begin
    repeat (6000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
